// ===== mdf_cfg.svh
`ifndef MDF_CFG_SVH
`define MDF_CFG_SVH

// ****************************************************************
// register offsets (word addresses on the serial port)
// ****************************************************************
`define MDF_OFS_DRIVER_OVERCURRENT_STATUS 6'h06
`define MDF_OFS_SYSTEM_ERROR_STATUS 6'h07
`define MDF_OFS_SYNC_PRD 6'h0C
`define MDF_OFS_FAULT_REACTION_MODE 6'h10

// ****************************************************************
// field positions
// ****************************************************************
`define MDF_BIT_PARITY 15
`define MDF_BIT_OC_C_HIGH 6
`define MDF_BIT_OC_B_HIGH 5
`define MDF_BIT_OC_A_HIGH 4
`define MDF_BIT_OC_C_LOW 2
`define MDF_BIT_OC_B_LOW 1
`define MDF_BIT_OC_A_LOW 0
`define MDF_BIT_MEM_ERR 4
`define MDF_BIT_PAR_ERR 2
`define MDF_BIT_BUS_ERR 1
`define MDF_BIT_FRAME_ERROR 0
`define MDF_BIT_MEM_GATE 8
`define MDF_BIT_SER_GATE 7
`define MDF_MSB_OC_MODE 6
`define MDF_LSB_OC_MODE 4
`define MDF_MSB_UV_MODE 3
`define MDF_LSB_UV_MODE 2
`define MDF_MSB_OT_MODE 1
`define MDF_LSB_OT_MODE 0

// ****************************************************************
// reset values and mode codes
// ****************************************************************
`define MDF_RST_STS 16'h0000
`define MDF_RST_FAULT_REACTION_MODE 16'h0115
`define MDF_WMASK_FAULT_REACTION_MODE 16'h01FF
`define MDF_OC_SLOW 3'h0
`define MDF_OC_FAST 3'h1
`define MDF_OC_LATCH 3'h2
`define MDF_OC_REPORT 3'h3
`define MDF_OC_OFF 3'h7
`define MDF_RV_SLOW 2'h0
`define MDF_RV_FAST 2'h1

// ****************************************************************
// timing (retry times in microseconds, clock 125 MHz)
// ****************************************************************
`define MDF_CLK_MHZ 125
`define MDF_SLOW_RETRY_US 5000
`define MDF_FAST_RETRY_US 500
`define MDF_RETRY_W 24

`endif

// ===== mdf_pkg.sv
package mdf_pkg;
    // phase overcurrent indications, one per transistor
    typedef struct packed {
        logic c_high;
        logic b_high;
        logic a_high;
        logic c_low;
        logic b_low;
        logic a_low;
    } mdf_oc_t;

    // serial and memory error events
    typedef struct packed {
        logic memory_load_error;
        logic parity_error;
        logic bus_contention_error;
        logic frame_error;
    } mdf_err_t;

    // register access from the serial port
    typedef struct packed {
        logic rd;
        logic wr;
        logic [5:0] addr;
        logic [15:0] wdata;
    } mdf_req_t;

    // fault reaction state
    typedef enum logic [1:0] {
        MDF_RUN = 2'b00,
        MDF_RETRY = 2'b01,
        MDF_LATCHED = 2'b10
    } mdf_state_t;
endpackage

// ===== mdf_fault_regs.sv
// ****************************************************************
// Overview of operation
// - bit 15 of each register carries frame parity when parity enabled
// - driver status bits 6,5,4 flag high-side overcurrent on C,B,A
// - driver status bits 2,1,0 flag low-side overcurrent on C,B,A
// - system status bit 4 reports memory load read error
// - system status bit 2 sets on serial frame parity error
// - system status bit 1 sets on serial bus contention
// - system status bit 0 sets on malformed serial frame
// - sync period register holds 12-bit measured period, read-only, resets zero
// - fault-mode bit 8: 0 enables memory fault reaction, resets 1
// - fault-mode bit 7: 0 enables serial fault reaction, resets 0
// - overcurrent codes 0/1: fault out, high-z, auto-retry slow/fast
// - overcurrent code 2: fault out, high-z, latched
// - code 3 reports only, code 7 disables, codes 4-6 reserved
// - undervoltage codes 0/1: fault out, high-z, retry slow/fast
// - overtemperature codes 0/1: fault out, high-z, retry slow/fast
// - fault-mode register resets to 0115h
// ****************************************************************
`include "mdf_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module mdf_fault_regs (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire mdf_pkg::mdf_req_t req,
    output logic [15:0] rdata,
    output logic rvalid,
    input wire logic serial_parity_enable,
    input wire mdf_pkg::mdf_oc_t oc_pins,
    input wire mdf_pkg::mdf_err_t err_evt,
    input wire logic undervoltage_in,
    input wire logic overtemperature_in,
    input wire logic pwm_sync_in,
    output logic fault_out_n,
    output logic predriver_hiz
);
    import mdf_pkg::*;

    localparam logic [`MDF_RETRY_W-1:0] SLOW_CYC =
        `MDF_RETRY_W'(`MDF_SLOW_RETRY_US * `MDF_CLK_MHZ);
    localparam logic [`MDF_RETRY_W-1:0] FAST_CYC =
        `MDF_RETRY_W'(`MDF_FAST_RETRY_US * `MDF_CLK_MHZ);

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    // pin-level detector outputs come from analogue comparators
    logic [5:0] oc_s1_ff, oc_s2_ff;
    logic [1:0] env_s1_ff, env_s2_ff;
    logic sync_s1_ff, sync_s2_ff, sync_s3_ff;

    // two stages only; edge detect uses the third stage
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            oc_s1_ff <= 6'h00;
            oc_s2_ff <= 6'h00;
            env_s1_ff <= 2'h0;
            env_s2_ff <= 2'h0;
            sync_s1_ff <= 1'b0;
            sync_s2_ff <= 1'b0;
            sync_s3_ff <= 1'b0;
        end else begin
            oc_s1_ff <= oc_pins;
            oc_s2_ff <= oc_s1_ff;
            env_s1_ff <= {undervoltage_in, overtemperature_in};
            env_s2_ff <= env_s1_ff;
            sync_s1_ff <= pwm_sync_in;
            sync_s2_ff <= sync_s1_ff;
            sync_s3_ff <= sync_s2_ff;
        end
    end

    logic uv_det, ot_det, oc_any;
    assign uv_det = env_s2_ff[1];
    assign ot_det = env_s2_ff[0];
    assign oc_any = |oc_s2_ff;

    // ****************************************************************
    // fault-mode register
    // ****************************************************************
    logic [15:0] mode_ff;

    // only bits 8..0 are writable; the rest stay zero
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mode_ff <= `MDF_RST_FAULT_REACTION_MODE;
        end else if (req.wr && req.addr == `MDF_OFS_FAULT_REACTION_MODE) begin
            mode_ff <= req.wdata & `MDF_WMASK_FAULT_REACTION_MODE;
        end
    end

    logic mem_gate, ser_gate;
    logic [2:0] oc_mode;
    logic [1:0] uv_mode, ot_mode;
    assign mem_gate = mode_ff[`MDF_BIT_MEM_GATE];
    assign ser_gate = mode_ff[`MDF_BIT_SER_GATE];
    assign oc_mode = mode_ff[`MDF_MSB_OC_MODE:`MDF_LSB_OC_MODE];
    assign uv_mode = mode_ff[`MDF_MSB_UV_MODE:`MDF_LSB_UV_MODE];
    assign ot_mode = mode_ff[`MDF_MSB_OT_MODE:`MDF_LSB_OT_MODE];

    // ****************************************************************
    // status registers
    // ****************************************************************
    logic [5:0] oc_sts_ff;
    logic [3:0] err_sts_ff;
    logic clr_drv, clr_sys;
    // reading a status register clears it; a new event in the same cycle wins
    assign clr_drv = req.rd && req.addr == `MDF_OFS_DRIVER_OVERCURRENT_STATUS;
    assign clr_sys = req.rd && req.addr == `MDF_OFS_SYSTEM_ERROR_STATUS;

    // overcurrent flags stick until read so a short pulse is not missed
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            oc_sts_ff <= 6'h00;
        end else begin
            oc_sts_ff <= (clr_drv ? 6'h00 : oc_sts_ff) | oc_s2_ff;
        end
    end

    // error flags from the serial engine and memory loader (same clock)
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            err_sts_ff <= 4'h0;
        end else begin
            err_sts_ff <= (clr_sys ? 4'h0 : err_sts_ff) | err_evt;
        end
    end

    // ****************************************************************
    // sync period measurement
    // ****************************************************************
    logic [11:0] prd_cnt_ff, prd_ff;
    logic sync_rise;
    assign sync_rise = sync_s2_ff && !sync_s3_ff;

    // counts cycles between rising edges; saturates so a slow input reads full scale
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            prd_cnt_ff <= 12'h000;
            prd_ff <= 12'h000;
        end else if (sync_rise) begin
            prd_ff <= prd_cnt_ff;
            prd_cnt_ff <= 12'h001;
        end else if (prd_cnt_ff != 12'hFFF) begin
            prd_cnt_ff <= prd_cnt_ff + 12'h001;
        end
    end

    // ****************************************************************
    // fault reaction
    // ****************************************************************
    logic oc_report, oc_hiz, uv_hiz, ot_hiz, sys_fault;
    // code 3 reports only, 7 and reserved 4..6 do nothing
    assign oc_report = oc_any && (oc_mode <= `MDF_OC_REPORT);
    assign oc_hiz = oc_any && (oc_mode <= `MDF_OC_LATCH);
    assign uv_hiz = uv_det && (uv_mode <= `MDF_RV_FAST);
    assign ot_hiz = ot_det && (ot_mode <= `MDF_RV_FAST);
    // gated system faults only report
    assign sys_fault = (!mem_gate && err_sts_ff[3]) ||
                       (!ser_gate && |err_sts_ff[2:0]);

    mdf_state_t state_ff;
    logic [`MDF_RETRY_W-1:0] retry_ff;
    logic slow_sel;

    // slow retry when the offending source is configured for it
    assign slow_sel = (oc_hiz && oc_mode == `MDF_OC_SLOW) ||
                      (uv_hiz && uv_mode == `MDF_RV_SLOW) ||
                      (ot_hiz && ot_mode == `MDF_RV_SLOW);

    // retry timer restarts while any high-z fault (overcurrent, undervoltage or overtemperature) persists
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= MDF_RUN;
            retry_ff <= '0;
        end else begin
            case (state_ff)
                MDF_RUN: begin
                    if (oc_hiz && oc_mode == `MDF_OC_LATCH) begin
                        state_ff <= MDF_LATCHED;
                    end else if (oc_hiz || uv_hiz || ot_hiz) begin
                        state_ff <= MDF_RETRY;
                        retry_ff <= slow_sel ? SLOW_CYC : FAST_CYC;
                    end
                end
                MDF_RETRY: begin
                    if (oc_hiz && oc_mode == `MDF_OC_LATCH) begin
                        state_ff <= MDF_LATCHED;
                    end else if (oc_hiz || uv_hiz || ot_hiz) begin
                        retry_ff <= slow_sel ? SLOW_CYC : FAST_CYC;
                    end else if (retry_ff <= `MDF_RETRY_W'(1)) begin
                        state_ff <= MDF_RUN; // auto recovery
                    end else begin
                        retry_ff <= retry_ff - `MDF_RETRY_W'(1);
                    end
                end
                MDF_LATCHED: begin
                    // leaves only when software picks a non-latched mode
                    if (oc_mode != `MDF_OC_LATCH) begin
                        state_ff <= MDF_RUN;
                    end
                end
                default: state_ff <= MDF_RUN;
            endcase
        end
    end

    // outputs registered to stay glitch free on pins
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            fault_out_n <= 1'b1;
            predriver_hiz <= 1'b0;
        end else begin
            predriver_hiz <= (state_ff != MDF_RUN);
            fault_out_n <= !((state_ff != MDF_RUN) || oc_report || sys_fault);
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    function automatic logic odd_parity(input logic [14:0] d);
        odd_parity = ~^d;
    endfunction

    logic [14:0] rd_body;
    // unmapped offsets and reserved bits read zero
    always_comb begin
        rd_body = 15'h0000;
        case (req.addr)
            `MDF_OFS_DRIVER_OVERCURRENT_STATUS: rd_body = {8'h00, oc_sts_ff[5:3], 1'b0, oc_sts_ff[2:0]};
            `MDF_OFS_SYSTEM_ERROR_STATUS: rd_body = {10'h000, err_sts_ff[3], 1'b0, err_sts_ff[2:0]};
            `MDF_OFS_SYNC_PRD: rd_body = {3'h0, prd_ff};
            `MDF_OFS_FAULT_REACTION_MODE: rd_body = mode_ff[14:0];
            default: rd_body = 15'h0000;
        endcase
    end

    // read data launched one cycle after the request
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= `MDF_RST_STS;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            if (req.rd) begin
                rdata <= {serial_parity_enable & odd_parity(rd_body), rd_body};
            end
        end
    end
endmodule

`default_nettype wire

// ===== mdf_fault_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************
// read answer checks
// ************************************
module mdf_fault_regs_chk (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire mdf_pkg::mdf_req_t req,
    input wire logic [15:0] rdata,
    input wire logic rvalid,
    input wire logic serial_parity_enable
);
    import mdf_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // a read at one offset and its answer an edge later
    sequence read_at(logic [5:0] a);
        req.rd && req.addr == a ##1 rvalid;
    endsequence
    // reserved bits of that answer must be zero
    property rsv_p(logic [5:0] a, logic [15:0] m);
        read_at(a) |-> (rdata & m) == 16'h0000;
    endproperty
    read_answer_a: assert property (req.rd |=> rvalid)
        else $error("read strobe not answered");
    answer_pulse_a: assert property (!req.rd |=> !rvalid)
        else $error("answer without read");
    // parity enable held steady so the answer word is judged fairly
    parity_odd_a: assert property (rvalid && serial_parity_enable && $past(serial_parity_enable)
        |-> ^rdata == 1'b1)
        else $error("answer parity not odd");
    parity_off_a: assert property (rvalid && !serial_parity_enable
        && !$past(serial_parity_enable) |-> !rdata[15])
        else $error("top bit set with parity off");
    drv_reserved_a: assert property (rsv_p(6'h06, 16'h7F88))
        else $error("driver status reserved bit set");
    sys_reserved_a: assert property (rsv_p(6'h07, 16'h7FE8))
        else $error("system status reserved bit set");
    sync_reserved_a: assert property (rsv_p(6'h0C, 16'h7000))
        else $error("sync period reserved bit set");
    mode_reserved_a: assert property (rsv_p(6'h10, 16'h7E00))
        else $error("fault mode reserved bit set");
endmodule
bind mdf_fault_regs mdf_fault_regs_chk chk_u (.ref_clk(ref_clk), .rstn(rstn), .req(req),
    .rdata(rdata), .rvalid(rvalid), .serial_parity_enable(serial_parity_enable));
`default_nettype wire

// ===== mdf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************
// host side of the register port
// ************************************
module mdf_host_model (
    input wire logic ref_clk,
    output var mdf_pkg::mdf_req_t req,
    input wire logic [15:0] rdata,
    input wire logic rvalid
);
    import mdf_pkg::*;
    initial req = '0;
    // idle address and data are inverted so stale values never look valid
    task automatic access(input logic r, input logic [5:0] a, input logic [15:0] d,
        output logic [15:0] q);
        @(posedge ref_clk);
        req <= '{rd: r, wr: !r, addr: a, wdata: d};
        @(posedge ref_clk);
        req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        @(posedge ref_clk);
        q = rvalid ? rdata : 16'hDEAD;
    endtask
endmodule
`default_nettype wire

// ===== tb_motor_driver_fault_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************
// register bank bench
// ************************************
module tb_motor_driver_fault_status_regs;
    import mdf_pkg::*;
    logic ref_clk, rstn, spe, uv, ot, sync;
    mdf_req_t req;
    mdf_oc_t oc;
    mdf_err_t err;
    logic [15:0] rdata, q;
    logic rvalid, fault_out_n, predriver_hiz;
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;
    mdf_fault_regs dut_u (.ref_clk(ref_clk), .rstn(rstn), .req(req), .rdata(rdata),
        .rvalid(rvalid), .serial_parity_enable(spe), .oc_pins(oc), .err_evt(err),
        .undervoltage_in(uv), .overtemperature_in(ot), .pwm_sync_in(sync),
        .fault_out_n(fault_out_n), .predriver_hiz(predriver_hiz));
    mdf_host_model host_u (.ref_clk(ref_clk), .req(req), .rdata(rdata), .rvalid(rvalid));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic complete_run();
        if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] exp);
        host_u.access(1'b1, a, 16'h0000, q);
        check(q, exp);
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        host_u.access(1'b0, a, d, q);
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // e is {fault_out_n, predriver_hiz}, sampled once the edge has settled
    task automatic flags(input logic [1:0] e);
        #1 check({14'h0000, fault_out_n, predriver_hiz}, {14'h0000, e});
    endtask
    task automatic do_reset();
        @(posedge ref_clk) rstn <= 1'b0;
        wait_clk(8);
        rstn <= 1'b1;
    endtask
    // a hang costs a mismatch and ends the run
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        rstn = 1'b0; spe = 1'b0; uv = 1'b0; ot = 1'b0; sync = 1'b0; oc = '0; err = '0;
        do_reset();
        rd(6'h06, 16'h0000);
        rd(6'h07, 16'h0000);
        rd(6'h10, 16'h0115);
        rd(6'h3F, 16'h0000);
        wr(6'h06, 16'hFFFF);
        wr(6'h0C, 16'hFFFF);
        rd(6'h06, 16'h0000);
        rd(6'h0C, 16'h0000);
        wr(6'h10, 16'hFFFF);
        rd(6'h10, 16'h01FF);
        // report only: every pin flags its own bit, driver stays enabled
        wr(6'h10, 16'h0135);
        for (int i = 0; i < 6; i++) begin
            @(posedge ref_clk) oc <= 6'(1 << i);
            wait_clk(5);
            flags(2'b00);
            @(posedge ref_clk) oc <= '0;
            // let the synchroniser drain so the clearing read is not re-set
            wait_clk(4);
            rd(6'h06, (i < 3) ? 16'(1 << i) : 16'(1 << (i + 1)));
        end
        wr(6'h10, 16'h0175);
        @(posedge ref_clk) oc <= 6'h3F;
        wait_clk(5);
        flags(2'b10);
        @(posedge ref_clk) oc <= '0;
        wait_clk(4);
        host_u.access(1'b1, 6'h06, 16'h0000, q);
        // latched: the fault outlives the pin until the mode leaves code 2
        wr(6'h10, 16'h0125);
        @(posedge ref_clk) oc <= 6'h02;
        wait_clk(5);
        @(posedge ref_clk) oc <= '0;
        wait_clk(20);
        flags(2'b01);
        rd(6'h06, 16'h0002);
        wr(6'h10, 16'h0135);
        wait_clk(3);
        flags(2'b10);
        spe <= 1'b1;
        wait_clk(2);
        rd(6'h10, 16'h0135);
        rd(6'h06, 16'h8000);
        spe <= 1'b0;
        // memory error first, while its fault gate is still off
        for (int j = 3; j >= 0; j--) begin
            @(posedge ref_clk) err <= 4'(1 << j);
            @(posedge ref_clk) err <= '0;
            wait_clk(3);
            if (j == 3) flags(2'b10);
            else flags(2'b00);
            rd(6'h07, (j == 3) ? 16'h0010 : 16'(1 << j));
        end
        do_reset();
        rd(6'h10, 16'h0115);
        repeat (3) begin
            @(posedge ref_clk) sync <= 1'b1;
            wait_clk(49);
            sync <= 1'b0;
            wait_clk(50);
        end
        wait_clk(10);
        rd(6'h0C, 16'h0064);
        @(posedge ref_clk) uv <= 1'b1;
        wait_clk(6);
        flags(2'b01);
        @(posedge ref_clk) uv <= 1'b0;
        wr(6'h10, 16'h0114);
        @(posedge ref_clk) ot <= 1'b1;
        wait_clk(6);
        flags(2'b01);
        complete_run();
    end
endmodule
`default_nettype wire
